// file: rtl/ssf_cmd_port.sv
// How it works
// R01: sync mode when clock pin high at release
// R02: transfer clock comes only from the programmer
// R03: input bits sampled on transfer clock rise
// R04: output bits change on transfer clock fall
// R05: eight-bit bytes, least significant bit first
// R06: busy pin high while transferring or working
// R07: programmer starts bytes only when busy low
// R08: all operations decoded from received command bytes
// R09: page read opcode returns 256-byte page
// R10: address mid then high, data ascending
// R11: block erase and erase-all with confirm byte
// R12: status byte then extended status byte
// R13: status shows ready and error flags kept until clear-status
// R14: clear-status resets both error flags
// R15: busy drops after clear-status completes
// R16: lock read returns one lock byte
// R17: boot area read returns page to byte 259
// R18: version bytes two to nine, always accepted
// R19: locked commands rejected until identity matches
// R20: blank flash accepts every command
// R21: after last byte, next byte is opcode
module ssf_cmd_port #(
   parameter logic [63:0] VERSION_DATA = 64'h0807060504030201 // arbitrary value
) (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_xfer_clk_pin,
   input wire logic i_serial_in_pin,
   output logic o_serial_out_pin,
   output logic o_busy_handshake_pin,
   output logic o_sync_mode,
   output ssf_pkg::ssf_mem_t o_mem,
   input wire logic [7:0] i_mem_rdata,
   input wire logic i_mem_rvalid,
   output ssf_pkg::ssf_erase_t o_erase,
   input wire logic i_flash_busy,
   input wire logic i_prog_fail,
   input wire logic i_erase_fail,
   input wire logic i_flash_blank,
   input wire logic [55:0] i_id_code
);
   import ssf_pkg::*;

   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_FETCH = 4'b0010,
      S_EXEC = 4'b0100,
      S_DRAIN = 4'b1000
   } ssf_state_t;

   // ==========================================================
   // link side, clocked by the programmer's transfer clock
   logic [2:0] bit_cnt;
   logic [7:0] rx_sr;
   logic [7:0] rx_byte;
   logic rx_tog;
   logic [7:0] tx_word;
   logic ack_tog;

   // shift in on rise, lsb first; a byte ends on the eighth rise
   always_ff @(posedge i_xfer_clk_pin or posedge i_rst) begin
      if (i_rst) begin
         bit_cnt <= 3'h0;
         rx_sr <= 8'h00;
         rx_byte <= 8'h00;
         rx_tog <= 1'b0;
      end else begin
         rx_sr <= {i_serial_in_pin, rx_sr[7:1]}; // [R03] [R05]
         bit_cnt <= bit_cnt + 3'h1;
         if (bit_cnt == LAST_BIT) begin
            rx_byte <= {i_serial_in_pin, rx_sr[7:1]}; // [R05]
            rx_tog <= ~rx_tog; // event toward system domain
         end
      end
   end

   // each fall puts out the bit that the following rise hands over;
   // tx_word moves only while busy is high, when no byte is running
   always_ff @(negedge i_xfer_clk_pin or posedge i_rst) begin
      if (i_rst) begin
         o_serial_out_pin <= SOUT_IDLE;
      end else begin
         o_serial_out_pin <= tx_word[bit_cnt]; // [R04] [R05]
      end
   end

   // ==========================================================
   // crossings into the system clock domain
   logic tog_meta;
   logic tog_sync;
   logic clk_meta;
   logic clk_sync;

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         tog_meta <= 1'b0;
         tog_sync <= 1'b0;
         clk_meta <= 1'b0;
         clk_sync <= 1'b0;
      end else begin
         tog_meta <= rx_tog;
         tog_sync <= tog_meta;
         clk_meta <= i_xfer_clk_pin;
         clk_sync <= clk_meta;
      end
   end

   // ==========================================================
   // mode capture: the pin level a few cycles after release
   logic [1:0] settle;
   logic mode_armed;

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         settle <= 2'h0;
         mode_armed <= 1'b0;
         o_sync_mode <= 1'b0;
      end else if (!mode_armed) begin
         settle <= settle + 2'h1;
         if (settle == MODE_SETTLE) begin
            mode_armed <= 1'b1;
            o_sync_mode <= clk_sync; // [R01] [R02]
         end
      end
   end

   // busy mixes link flops and system flops; only one side moves
   // at a time, so the pin sees no glitch. high from the first
   // rise of a byte until the system side has finished with it
   assign o_busy_handshake_pin = o_sync_mode
      & ((bit_cnt != 3'h0) | (rx_tog ^ ack_tog)); // [R06] [R07]

   // ==========================================================
   // command interpreter
   ssf_state_t state;
   logic [7:0] opcode;
   logic [8:0] slot;
   logic [15:0] page;
   logic [7:0] offset;
   logic id_ok;
   logic id_match;
   logic err_a;
   logic err_b;
   logic pend;
   logic accept;
   logic clear_req;
   logic byte_done;
   logic [7:0] status_main;
   logic [7:0] status_ext;
   logic [2:0] id_idx;
   logic [7:0] id_byte;
   logic [8:0] next_slot;
   logic [7:0] next_offset;

   assign pend = o_sync_mode & (tog_sync ^ ack_tog);
   assign next_slot = slot + 9'h001;
   assign next_offset = offset + 8'h01;
   assign id_idx = 3'(slot - SLOT_ID_FIRST);
   assign id_byte = i_id_code[{id_idx, 3'h0} +: 8];

   // opcodes honoured without a passed identity check
   always_comb begin
      accept = i_flash_blank | id_ok; // [R19] [R20]
      if (rx_byte == OP_READ_STATUS || rx_byte == OP_ID_CHECK
         || rx_byte == OP_VERSION) begin
         accept = 1'b1; // [R18]
      end
   end

   // status bytes built from live flash state and error flags
   always_comb begin
      status_main = 8'h00;
      status_main[ST_READY] = ~i_flash_busy; // [R13]
      status_main[ST_ERASE_ERR] = err_b; // [R13]
      status_main[ST_PROG_ERR] = err_a; // [R13]
      status_ext = 8'h00;
      status_ext[EXT_BLANK] = i_flash_blank;
      status_ext[EXT_ID_OK] = id_ok;
   end

   assign clear_req = (state == S_IDLE) & pend & (slot == SLOT_OPCODE)
      & accept & (rx_byte == OP_CLEAR_STATUS);

   // a byte is acknowledged once its work is over and the next
   // transmit byte is in place; that is what drops busy
   always_comb begin
      byte_done = 1'b0;
      unique case (state)
         S_IDLE: byte_done = pend & ~o_mem.rd & ~o_erase.req;
         S_FETCH: byte_done = i_mem_rvalid;
         S_EXEC: byte_done = 1'b0;
         S_DRAIN: byte_done = ~i_flash_busy;
      endcase
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         ack_tog <= 1'b0;
      end else if (byte_done && (state != S_IDLE || !next_is_wait())) begin
         ack_tog <= ~ack_tog; // [R15]
      end
   end

   // true when the byte now pending starts a fetch or an erase
   function automatic logic next_is_wait();
      logic w;
      w = 1'b0;
      if (slot != SLOT_OPCODE) begin
         unique case (opcode)
            OP_PAGE_READ, OP_BOOT_READ:
               w = (slot >= SLOT_ADDR_HIGH) && (slot != SLOT_PAGE_LAST);
            OP_READ_LOCK: w = (slot == SLOT_ADDR_HIGH);
            OP_BLOCK_ERASE:
               w = (slot == SLOT_ERASE_CONFIRM) && (rx_byte == OP_CONFIRM);
            OP_ERASE_ALL:
               w = (slot == SLOT_ALL_CONFIRM) && (rx_byte == OP_CONFIRM);
            default: w = 1'b0;
         endcase
      end
      return w;
   endfunction

   // error flags: a failure in the cycle of a clear still lands
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         err_a <= 1'b0;
         err_b <= 1'b0;
      end else begin
         err_a <= i_prog_fail | (err_a & ~clear_req); // [R14]
         err_b <= i_erase_fail | (err_b & ~clear_req); // [R14]
      end
   end

   // main sequencer: slot counting, decode, transmit staging
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         state <= S_IDLE;
         opcode <= 8'h00;
         slot <= SLOT_OPCODE;
         page <= 16'h0000;
         offset <= 8'h00;
         id_ok <= 1'b0;
         id_match <= 1'b0;
         tx_word <= TX_FILL;
         o_mem <= '0;
         o_erase <= '0;
      end else begin
         o_mem.rd <= 1'b0;
         o_mem.we <= 1'b0;
         o_erase.req <= 1'b0;
         unique case (state)
            S_IDLE: begin
               if (pend && !o_mem.rd && !o_erase.req) begin
                  slot <= next_slot;
                  tx_word <= TX_FILL;
                  if (slot == SLOT_OPCODE) begin
                     opcode <= rx_byte; // [R08]
                     if (!accept || rx_byte == OP_CLEAR_STATUS) begin
                        slot <= SLOT_OPCODE; // [R19] [R15]
                     end else if (rx_byte == OP_READ_STATUS) begin
                        tx_word <= status_main; // [R12]
                     end else if (rx_byte == OP_VERSION) begin
                        tx_word <= VERSION_DATA[7:0]; // [R18]
                     end
                  end else begin
                     if (slot == SLOT_ADDR_MID && opcode != OP_ID_CHECK) page[7:0] <= rx_byte; // [R10]
                     if (slot == SLOT_ADDR_HIGH && opcode != OP_ID_CHECK) page[15:8] <= rx_byte; // [R10]
                     unique case (opcode)
                        OP_PAGE_READ, OP_BOOT_READ: begin
                           o_mem.area <= (opcode == OP_BOOT_READ) ? AREA_BOOT : AREA_USER;
                           if (slot == SLOT_ADDR_HIGH) begin
                              offset <= 8'h00;
                              o_mem.addr <= {rx_byte, page[7:0], 8'h00}; // [R09]
                              o_mem.rd <= 1'b1;
                              state <= S_FETCH;
                           end else if (slot == SLOT_PAGE_LAST) begin
                              slot <= SLOT_OPCODE; // [R21] [R17]
                           end else if (slot > SLOT_ADDR_HIGH) begin
                              offset <= next_offset;
                              o_mem.addr <= {page, next_offset}; // [R10]
                              o_mem.rd <= 1'b1;
                              state <= S_FETCH;
                           end
                        end
                        OP_PAGE_PROG: begin
                           if (slot == SLOT_ADDR_HIGH) begin
                              offset <= 8'h00;
                           end else if (slot > SLOT_ADDR_HIGH) begin
                              o_mem.area <= AREA_USER;
                              o_mem.addr <= {page, offset};
                              o_mem.wdata <= rx_byte;
                              o_mem.we <= 1'b1;
                              offset <= next_offset;
                              if (slot == SLOT_PAGE_LAST) begin
                                 slot <= SLOT_OPCODE; // [R21]
                              end
                           end
                        end
                        OP_BLOCK_ERASE: begin
                           if (slot == SLOT_ERASE_CONFIRM) begin
                              slot <= SLOT_OPCODE; // [R21]
                              if (rx_byte == OP_CONFIRM) begin
                                 o_erase.req <= 1'b1; // [R11]
                                 o_erase.all <= 1'b0;
                                 o_erase.page <= page;
                                 state <= S_EXEC;
                              end
                           end
                        end
                        OP_ERASE_ALL: begin
                           slot <= SLOT_OPCODE; // [R21]
                           if (rx_byte == OP_CONFIRM) begin
                              o_erase.req <= 1'b1; // [R11]
                              o_erase.all <= 1'b1;
                              state <= S_EXEC;
                           end
                        end
                        OP_READ_STATUS: begin
                           if (slot == SLOT_STATUS_EXT) slot <= SLOT_OPCODE; // [R21]
                           else tx_word <= status_ext; // [R12]
                        end
                        OP_READ_LOCK: begin
                           if (slot == SLOT_ADDR_HIGH) begin
                              o_mem.area <= AREA_LOCK;
                              o_mem.addr <= {rx_byte, page[7:0], 8'h00}; // [R16]
                              o_mem.rd <= 1'b1;
                              state <= S_FETCH;
                           end else if (slot == SLOT_LOCK_DATA) begin
                              slot <= SLOT_OPCODE; // [R21]
                           end
                        end
                        OP_VERSION: begin
                           if (slot == SLOT_VERSION_LAST) slot <= SLOT_OPCODE; // [R21]
                           else tx_word <= VERSION_DATA[{slot[2:0], 3'h0} +: 8]; // [R18]
                        end
                        OP_ID_CHECK: begin
                           if (slot == SLOT_ID_FIRST) begin
                              id_match <= (rx_byte == id_byte);
                           end else if (slot > SLOT_ID_FIRST) begin
                              id_match <= id_match & (rx_byte == id_byte);
                           end
                           if (slot == SLOT_ID_LAST) begin
                              id_ok <= id_match & (rx_byte == id_byte); // [R19]
                              slot <= SLOT_OPCODE; // [R21]
                           end
                        end
                        default: slot <= SLOT_OPCODE; // [R21]
                     endcase
                  end
               end
            end
            S_FETCH: begin
               if (i_mem_rvalid) begin
                  tx_word <= i_mem_rdata; // [R09] [R16] [R17]
                  state <= S_IDLE;
               end
            end
            S_EXEC: begin
               if (i_flash_busy) state <= S_DRAIN; // [R06]
            end
            S_DRAIN: begin
               if (!i_flash_busy) state <= S_IDLE;
            end
         endcase
      end
   end
endmodule

// file: rtl/ssf_pkg.sv
package ssf_pkg;
   // ==========================================================
   // command opcodes, first byte of every transaction, and the erase confirm byte
   localparam logic [7:0] OP_PAGE_READ = 8'hff;
   localparam logic [7:0] OP_PAGE_PROG = 8'h41;
   localparam logic [7:0] OP_BLOCK_ERASE = 8'h20;
   localparam logic [7:0] OP_ERASE_ALL = 8'ha7;
   localparam logic [7:0] OP_CONFIRM = 8'hd0;
   localparam logic [7:0] OP_READ_STATUS = 8'h70;
   localparam logic [7:0] OP_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] OP_READ_LOCK = 8'h71;
   localparam logic [7:0] OP_ID_CHECK = 8'hf5;
   localparam logic [7:0] OP_VERSION = 8'hfb;
   localparam logic [7:0] OP_BOOT_READ = 8'hfc;

   // ==========================================================
   // byte slots within a transaction, opcode is slot 0
   localparam logic [8:0] SLOT_OPCODE = 9'h000;
   localparam logic [8:0] SLOT_ADDR_MID = 9'h001;
   localparam logic [8:0] SLOT_ADDR_HIGH = 9'h002;
   localparam logic [8:0] SLOT_ERASE_CONFIRM = 9'h003;
   localparam logic [8:0] SLOT_ALL_CONFIRM = 9'h001;
   localparam logic [8:0] SLOT_STATUS_EXT = 9'h002;
   localparam logic [8:0] SLOT_LOCK_DATA = 9'h003;
   localparam logic [8:0] SLOT_VERSION_LAST = 9'h008;
   localparam logic [8:0] SLOT_ID_FIRST = 9'h005;
   localparam logic [8:0] SLOT_ID_LAST = 9'h00b;
   localparam logic [8:0] SLOT_PAGE_LAST = 9'h102;

   // ==========================================================
   // link framing and reset values
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic SOUT_IDLE = 1'b1;
   localparam logic [7:0] TX_FILL = 8'hff;
   localparam logic [1:0] MODE_SETTLE = 2'h3;

   // ==========================================================
   // status byte layout
   localparam int ST_READY = 7;
   localparam int ST_ERASE_ERR = 5;
   localparam int ST_PROG_ERR = 4;
   localparam int EXT_BLANK = 3;
   localparam int EXT_ID_OK = 2;

   // ==========================================================
   // carriers toward the flash array
   typedef enum logic [1:0] {
      AREA_USER = 2'h0,
      AREA_BOOT = 2'h1,
      AREA_LOCK = 2'h2
   } ssf_area_t;

   typedef struct packed {
      logic rd;
      logic we;
      ssf_area_t area;
      logic [23:0] addr;
      logic [7:0] wdata;
   } ssf_mem_t;

   typedef struct packed {
      logic req;
      logic all;
      logic [15:0] page;
   } ssf_erase_t;
endpackage

// file: bench/ssf_cmd_port_properties.sv
// ==========================================================
// port checker for the serial command port
module ssf_cmd_port_properties (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_xfer_clk_pin,
   input wire logic o_busy_handshake_pin,
   input wire logic o_sync_mode,
   input wire ssf_pkg::ssf_mem_t o_mem,
   input wire ssf_pkg::ssf_erase_t o_erase,
   input wire logic i_flash_busy
);
   timeunit 1ns;
   timeprecision 100ps;
   import ssf_pkg::*;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);

   // a byte begins with a transfer clock rise once the mode is taken
   sequence s_byte_start;
      $rose(i_xfer_clk_pin) && o_sync_mode;
   endsequence
   // a byte lasts longer than eight system cycles, so busy may not flicker
   sequence s_busy_run;
      o_busy_handshake_pin [*8];
   endsequence

   property p_quiet_mode;
      !o_sync_mode |-> !o_busy_handshake_pin;
   endproperty
   property p_mode_kept;
      o_sync_mode |=> o_sync_mode;
   endproperty
   property p_busy_on_rx;
      s_byte_start |-> ##[0:2] o_busy_handshake_pin;
   endproperty
   property p_busy_hold;
      $rose(o_busy_handshake_pin) |-> s_busy_run;
   endproperty
   property p_release_idle;
      $fell(o_busy_handshake_pin) |-> i_xfer_clk_pin && !i_flash_busy;
   endproperty
   property p_fetch_busy;
      o_mem.rd |-> !o_mem.we ##0 o_busy_handshake_pin [*2];
   endproperty
   property p_erase_pulse;
      o_erase.req |-> o_busy_handshake_pin ##1 !o_erase.req;
   endproperty
   property p_erase_busy;
      i_flash_busy && o_sync_mode |-> o_busy_handshake_pin;
   endproperty

   a_quiet_mode: assert property (p_quiet_mode) else $error("busy outside sync mode");
   a_mode_kept: assert property (p_mode_kept) else $error("sync mode lost");
   a_busy_on_rx: assert property (p_busy_on_rx) else $error("busy late on receive");
   a_busy_hold: assert property (p_busy_hold) else $error("busy pulse too short");
   a_release_idle: assert property (p_release_idle) else $error("busy dropped while working");
   a_fetch_busy: assert property (p_fetch_busy) else $error("fetch while not busy");
   a_erase_pulse: assert property (p_erase_pulse) else $error("bad erase request");
   a_erase_busy: assert property (p_erase_busy) else $error("idle while erasing");
endmodule

bind ssf_cmd_port ssf_cmd_port_properties i_ssf_cmd_port_properties (
   .i_sys_clk(i_sys_clk),
   .i_rst(i_rst),
   .i_xfer_clk_pin(i_xfer_clk_pin),
   .o_busy_handshake_pin(o_busy_handshake_pin),
   .o_sync_mode(o_sync_mode),
   .o_mem(o_mem),
   .o_erase(o_erase),
   .i_flash_busy(i_flash_busy)
);

// file: bench/ssf_programmer_model.sv
// ==========================================================
// serial programmer that owns the transfer clock
module ssf_programmer_model (
   input wire logic i_busy,
   input wire logic i_sout,
   output logic o_clk,
   output logic o_sin,
   output logic o_hang
);
   timeunit 1ns;
   timeprecision 100ps;

   // clock held high through reset so the device takes sync mode
   initial begin
      o_clk = 1'b1;
      o_sin = 1'b1;
      o_hang = 1'b0;
   end

   // one byte, 32 ns per bit; clock stands high between bytes
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      int n;
      for (n = 0; n < 4000 && i_busy !== 1'b0; n++) #5;
      if (n == 4000) o_hang = 1'b1;
      for (int b = 0; b < 8; b++) begin
         o_clk = 1'b0;
         o_sin = tx[b];
         #16;
         o_clk = 1'b1;
         rx[b] = i_sout;
         #16;
      end
      o_sin = ~o_sin; // no stale level left on the data line
   endtask
endmodule

// file: bench/ssf_cmd_port_tb.sv
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
   $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end

module ssf_cmd_port_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import ssf_pkg::*;
   localparam logic [63:0] VER = 64'h8877665544332211; // arbitrary value
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] mem_rdata = 8'h00;
   logic mem_rvalid = 1'b0;
   logic flash_busy = 1'b0;
   logic erase_fail = 1'b0;
   logic flash_blank = 1'b0;
   logic [55:0] id_code = 56'h5a4b3c2d1e0f99; // arbitrary value
   logic xclk, sin, sout, busy, sync, hang;
   ssf_mem_t mem;
   ssf_erase_t erase;
   int error_cnt = 0;
   int n_checks = 0;
   int rd_cnt = 0;
   int er_cnt = 0;
   int fb_cnt = 0;
   logic [15:0] er_page = 16'h0000;
   logic er_all = 1'b0;
   logic fail_next = 1'b0;
   logic prog_fail = 1'b0;
   int wr_cnt = 0;
   int wr_bad = 0;

   always #12.5 clk = ~clk;

   ssf_cmd_port #(.VERSION_DATA(VER)) i_ssf_cmd_port (
      .i_sys_clk(clk), .i_rst(rst), .i_xfer_clk_pin(xclk), .i_serial_in_pin(sin),
      .o_serial_out_pin(sout), .o_busy_handshake_pin(busy), .o_sync_mode(sync),
      .o_mem(mem), .i_mem_rdata(mem_rdata), .i_mem_rvalid(mem_rvalid), .o_erase(erase),
      .i_flash_busy(flash_busy), .i_prog_fail(prog_fail), .i_erase_fail(erase_fail),
      .i_flash_blank(flash_blank), .i_id_code(id_code)
   );

   ssf_programmer_model i_ssf_programmer_model (
      .i_busy(busy), .i_sout(sout), .o_clk(xclk), .o_sin(sin), .o_hang(hang)
   );

   // ==========================================================
   // flash array stand-in: lock reads ignore the page offset
   function automatic logic [7:0] mval(ssf_area_t a, logic [23:0] ad);
      return (a == AREA_LOCK ? 8'h00 : ad[7:0]) ^ ad[15:8] ^ ad[23:16] ^ {a, 6'h00};
   endfunction

   // reads answer after one cycle; an erase keeps the array busy 40 cycles
   always @(posedge clk) begin
      mem_rvalid <= mem.rd;
      mem_rdata <= mval(mem.area, mem.addr);
      if (mem.rd) rd_cnt <= rd_cnt + 1;
      if (erase.req) begin
         er_cnt <= er_cnt + 1;
         er_page <= erase.page;
         er_all <= erase.all;
         fb_cnt <= 40;
      end else if (fb_cnt != 0) fb_cnt <= fb_cnt - 1;
      flash_busy <= erase.req || fb_cnt > 1;
      erase_fail <= fb_cnt == 1 && fail_next;
      // page program: data byte k must land at offset k of page 0312
      if (mem.we) begin
         wr_cnt <= wr_cnt + 1;
         if (mem.area != AREA_USER || mem.addr[23:8] != 16'h0312 || mem.wdata != (mem.addr[7:0] ^ 8'h5a))
            wr_bad <= wr_bad + 1;
      end
   end

   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // a stuck busy line ends the run through the same report
   always @(posedge hang) begin
      error_cnt++;
      close_out();
   end

   // ==========================================================
   // scenarios
   task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
      i_ssf_programmer_model.xfer(tx, rx);
   endtask

   task automatic status(output logic [7:0] m, output logic [7:0] e);
      xb(OP_READ_STATUS, m);
      xb(8'hff, m);
      xb(8'hff, e);
   endtask

   task automatic t_version();
      logic [7:0] r;
      xb(OP_VERSION, r);
      for (int k = 0; k < 8; k++) begin
         xb(8'hff, r);
         `CHK(r, VER[8*k +: 8])
      end
   endtask

   task automatic t_locked();
      logic [7:0] m, e;
      xb(OP_PAGE_READ, m);
      xb(8'h00, m);
      xb(8'h00, m);
      status(m, e);
      `CHK(rd_cnt, 0)
      `CHK({m[7], m[5], m[4]}, 3'h4)
      `CHK(e[3:2], 2'h0)
   endtask

   task automatic t_blank_lock();
      logic [7:0] r, e;
      @(posedge clk) flash_blank <= 1'b1;
      xb(OP_READ_LOCK, r);
      xb(8'h34, r);
      xb(8'h02, r);
      xb(8'hff, r);
      `CHK(r, mval(AREA_LOCK, 24'h023400))
      status(r, e);
      `CHK(e[3], 1'b1)
      @(posedge clk) flash_blank <= 1'b0;
   endtask

   task automatic t_id();
      logic [7:0] m, e;
      xb(OP_ID_CHECK, m);
      for (int k = 0; k < 3; k++) xb(8'h00, m);
      xb(8'h07, m);
      for (int k = 0; k < 7; k++) xb(id_code[8*k +: 8], m);
      status(m, e);
      `CHK(e[2], 1'b1)
   endtask

   task automatic t_page(input logic [7:0] op, input ssf_area_t a);
      logic [7:0] r;
      xb(op, r);
      xb(8'h12, r);
      xb(8'h03, r);
      for (int k = 0; k < 256; k++) begin
         xb(8'hff, r);
         `CHK(r, mval(a, {16'h0312, k[7:0]}))
      end
   endtask

   task automatic t_prog();
      logic [7:0] m, e;
      xb(OP_PAGE_PROG, m);
      xb(8'h12, m);
      xb(8'h03, m);
      for (int k = 0; k < 256; k++) xb(k[7:0] ^ 8'h5a, m);
      @(posedge clk) prog_fail <= 1'b1;
      @(posedge clk) prog_fail <= 1'b0;
      status(m, e);
      `CHK(wr_cnt, 256)
      `CHK(wr_bad, 0)
      `CHK(m[4], 1'b1)
   endtask

   task automatic t_erase();
      logic [7:0] m, e;
      fail_next = 1'b1;
      xb(OP_BLOCK_ERASE, m);
      xb(8'h56, m);
      xb(8'h01, m);
      xb(OP_CONFIRM, m);
      status(m, e);
      `CHK({er_page, er_all}, 17'h002ac)
      `CHK(m[5:4], 2'h3)
      xb(OP_CLEAR_STATUS, m);
      status(m, e);
      `CHK(m[5:4], 2'h0)
      fail_next = 1'b0;
      xb(OP_BLOCK_ERASE, m);
      xb(8'h56, m);
      xb(8'h01, m);
      xb(8'h00, m);
      xb(OP_ERASE_ALL, m);
      xb(OP_CONFIRM, m);
      status(m, e);
      `CHK(er_cnt, 2)
      `CHK(er_all, 1'b1)
   endtask

   // reset for 12 cycles, wait for the mode, then run each scenario
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      for (int n = 0; n < 20 && sync !== 1'b1; n++) @(posedge clk);
      `CHK(sync, 1'b1)
      t_version();
      t_locked();
      t_blank_lock();
      t_id();
      t_page(OP_PAGE_READ, AREA_USER);
      t_page(OP_BOOT_READ, AREA_BOOT);
      t_prog();
      t_erase();
      close_out();
   end
endmodule
